/* File: hdl/capcmp_pkg.sv */
package capcmp_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_CAP_LOW = 8'h0c;
  localparam logic [7:0] OFS_CAP_HIGH = 8'h10;
  localparam logic [7:0] OFS_CMP_A_LOW = 8'h14;
  localparam logic [7:0] OFS_CMP_A_HIGH = 8'h18;
  localparam logic [7:0] OFS_CMP_B_LOW = 8'h1c;
  localparam logic [7:0] OFS_CMP_B_HIGH = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_FLAGS = 8'h28;
  localparam logic [7:0] OFS_CMP_CTRL = 8'h2c;
  localparam logic [7:0] OFS_OUT_STATE = 8'h30;

  // Field positions.
  localparam int CTRL_A_ACT_A_LSB = 6;
  localparam int CTRL_A_ACT_B_LSB = 4;
  localparam int CTRL_A_WGM_LSB = 0;
  localparam int CTRL_B_FILTER_BIT = 7;
  localparam int CTRL_B_EDGE_BIT = 6;
  localparam int CTRL_B_WGM_LSB = 3;
  localparam int CTRL_C_FORCE_A_BIT = 7;
  localparam int CTRL_C_FORCE_B_BIT = 6;
  localparam int FLAG_CAP_BIT = 0;
  localparam int FLAG_CMP_A_BIT = 1;
  localparam int FLAG_CMP_B_BIT = 2;
  localparam int CMP_CTRL_SELECT_BIT = 0;

  // Reset values and timing counts.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam int SYNC_STAGES = 3;
  localparam int FILTER_SAMPLES = 4;

  // Waveform mode codes with special meaning here.
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_CMP = 4'h4;
  localparam logic [3:0] WGM_PFC_CAP = 4'h8;
  localparam logic [3:0] WGM_PFC_CMP = 4'h9;
  localparam logic [3:0] WGM_PC_CAP = 4'ha;
  localparam logic [3:0] WGM_CTC_CAP = 4'hc;
  localparam logic [3:0] WGM_RESERVED = 4'hd;
  localparam logic [3:0] WGM_FAST_CAP = 4'he;

  // Signals from the counter unit.
  typedef struct packed {
    logic [15:0] value;
    logic tick;
    logic written;
    logic at_top;
    logic at_floor;
  } counter_status_t;

  // Per compare unit settings: buffering and load point decoded from the mode, plus the action bits.
  typedef struct packed {
    logic buffered;
    logic floor_load;
    logic [1:0] action;
  } compare_cfg_t;

endpackage : capcmp_pkg

/* File: hdl/capture_filter.sv */
`timescale 1ns/1ps
`default_nettype none
module capture_filter
  import capcmp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Trigger sources and settings.
  input wire logic pin_i,
  input wire logic comparator_i,
  input wire logic source_select_i,
  input wire logic filter_enable_i,
  input wire logic rising_edge_i,
  input wire logic enable_i,
  // Qualified edge, one cycle.
  output logic event_o
);

  logic [SYNC_STAGES-1:0] pin_sync_ff;
  logic [SYNC_STAGES-1:0] cmp_sync_ff;
  logic pin_level_ff;
  logic cmp_level_ff;
  logic [FILTER_SAMPLES-2:0] window_ff;
  logic [FILTER_SAMPLES-1:0] samples;
  logic filtered_ff;
  logic prev_ff;
  logic selected;
  logic detect_in;

  // Both sources are synchronised all the time, so switching source can show as an edge.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_sync_ff <= '0;
      cmp_sync_ff <= '0;
      pin_level_ff <= 1'b0;
      cmp_level_ff <= 1'b0;
    end
    else
    begin
      pin_sync_ff <= {pin_sync_ff[SYNC_STAGES-2:0], pin_i};
      cmp_sync_ff <= {cmp_sync_ff[SYNC_STAGES-2:0], comparator_i};
      if (pin_sync_ff[1] == pin_sync_ff[2])
        pin_level_ff <= pin_sync_ff[2];
      if (cmp_sync_ff[1] == cmp_sync_ff[2])
        cmp_level_ff <= cmp_sync_ff[2];
    end
  end

  assign selected = source_select_i ? cmp_level_ff : pin_level_ff;

  // The newest sample joins the stored ones, so the delay is exactly one cycle per sample.
  assign samples = {window_ff, selected};

  // The filter output only moves when the whole sample window agrees.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      window_ff <= '0;
      filtered_ff <= 1'b0;
    end
    else
    begin
      window_ff <= samples[FILTER_SAMPLES-2:0];
      if (&samples || ~|samples)
        filtered_ff <= selected;
    end
  end

  assign detect_in = filter_enable_i ? filtered_ff : selected;

  // Edge detector history.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prev_ff <= 1'b0;
    else
      prev_ff <= detect_in;
  end

  // Edge polarity chosen by software; disabled modes see no events.
  assign event_o = enable_i & (rising_edge_i ? (detect_in & ~prev_ff) : (~detect_in & prev_ff));

endmodule : capture_filter
`default_nettype wire

/* File: hdl/compare_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module compare_unit
  import capcmp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Counter and settings.
  input wire counter_status_t counter_i,
  input wire compare_cfg_t cfg_i,
  // CPU side.
  input wire logic commit_i,
  input wire logic [15:0] value_i,
  input wire logic force_i,
  input wire logic flag_clear_i,
  output logic [15:0] cpu_view_o,
  output logic [15:0] active_o,
  // Results.
  output logic match_o,
  output logic flag_o,
  output logic state_o
);

  logic [15:0] buffer_ff;
  logic [15:0] active_ff;
  logic block_ff;
  logic flag_ff;
  logic state_ff;
  logic load;
  logic act;

  // A counter write blocks the match at the next timer tick, stopped or not.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      block_ff <= 1'b0;
    else if (counter_i.written)
      block_ff <= 1'b1;
    else if (counter_i.tick)
      block_ff <= 1'b0;
  end

  assign match_o = counter_i.tick & ~block_ff & (counter_i.value == active_ff);
  assign load = cfg_i.buffered & counter_i.tick & (cfg_i.floor_load ? counter_i.at_floor : counter_i.at_top);

  // Buffer and active compare value; the buffer is only in use in PWM modes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      buffer_ff <= VALUE_RESET;
      active_ff <= VALUE_RESET;
    end
    else
    begin
      if (commit_i)
        buffer_ff <= value_i;
      if (commit_i && !cfg_i.buffered)
        active_ff <= value_i;
      else if (load)
        active_ff <= buffer_ff;
    end
  end

  // Hardware set wins over a clear in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_ff <= 1'b0;
    else if (match_o)
      flag_ff <= 1'b1;
    else if (flag_clear_i)
      flag_ff <= 1'b0;
  end

  // Action bits act at once; the state is kept across mode changes.
  assign act = ~cfg_i.buffered & (match_o | force_i);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_ff <= 1'b0;
    else if (act)
      case (cfg_i.action)
        2'h1: state_ff <= ~state_ff;
        2'h2: state_ff <= 1'b0;
        2'h3: state_ff <= 1'b1;
        default: state_ff <= state_ff;
      endcase
  end

  assign cpu_view_o = cfg_i.buffered ? buffer_ff : active_ff;
  assign active_o = active_ff;
  assign flag_o = flag_ff;
  assign state_o = state_ff;

endmodule : compare_unit
`default_nettype wire

/* File: hdl/timer_capture_compare_units.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_units
  import capcmp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  output logic ack_o,
  // Capture sources.
  input wire logic capture_input_pin_i,
  input wire logic comparator_result_i,
  // Counter unit.
  input wire counter_status_t counter_i,
  // Interrupt requests and acknowledges (capture, compare A, compare B).
  output logic capture_irq_o,
  output logic compare_a_irq_o,
  output logic compare_b_irq_o,
  input wire logic [2:0] irq_ack_i,
  // Waveform generator side.
  output logic match_a_o,
  output logic match_b_o,
  output logic [3:0] waveform_mode_select_o,
  output logic [15:0] ceiling_value_o,
  output logic [1:0] compare_output_state_o
);

  // Mode decode helpers, each used in several places.
  function automatic logic is_pwm(input logic [3:0] mode);
    is_pwm = !(mode == WGM_NORMAL || mode == WGM_CTC_CMP || mode == WGM_CTC_CAP || mode == WGM_RESERVED);
  endfunction : is_pwm

  function automatic logic capture_is_ceiling(input logic [3:0] mode);
    capture_is_ceiling = (mode == WGM_PFC_CAP) || (mode == WGM_PC_CAP) ||
                         (mode == WGM_CTC_CAP) || (mode == WGM_FAST_CAP);
  endfunction : capture_is_ceiling

  function automatic logic loads_at_floor(input logic [3:0] mode);
    loads_at_floor = (mode == WGM_PFC_CAP) || (mode == WGM_PFC_CMP);
  endfunction : loads_at_floor

  // Software visible state.
  logic [7:0] timer_ctrl_a_ff;
  logic [7:0] timer_ctrl_b_ff;
  logic [7:0] holding_ff;
  logic [15:0] capture_register_ff;
  logic capture_flag_ff;
  logic [2:0] irq_mask_reg_ff;
  logic comparator_capture_select_ff;
  logic ack_ff;
  logic [7:0] rd_data_ff;
  logic [15:0] ceiling_ff;

  // Decoded access strobes.
  logic access;
  logic wr;
  logic rd;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_ctrl_c;
  logic wr_cap_low;
  logic wr_any_high;
  logic wr_cmp_a_low;
  logic wr_cmp_b_low;
  logic wr_irq_mask;
  logic wr_flags;
  logic wr_cmp_ctrl;
  logic rd_cap_low;
  logic [7:0] nxt_rd_data;

  // Mode and unit wiring.
  logic [3:0] mode;
  logic capture_enable;
  logic capture_event;
  compare_cfg_t cfg_a;
  compare_cfg_t cfg_b;
  logic [15:0] view_a;
  logic [15:0] view_b;
  logic [15:0] active_a;
  logic [15:0] active_b;
  logic flag_a;
  logic flag_b;
  logic state_a;
  logic state_b;
  logic force_a;
  logic force_b;
  logic clear_a;
  logic clear_b;

  // A request is taken in the cycle before ack rises, exactly once per transfer.
  assign access = cyc_i & stb_i & ~ack_ff;
  assign wr = access & we_i & sel_i[0];
  assign rd = access & ~we_i;

  assign wr_ctrl_a = wr && (adr_i == OFS_CTRL_A);
  assign wr_ctrl_b = wr && (adr_i == OFS_CTRL_B);
  assign wr_ctrl_c = wr && (adr_i == OFS_CTRL_C);
  assign wr_cap_low = wr && (adr_i == OFS_CAP_LOW);
  assign wr_cmp_a_low = wr && (adr_i == OFS_CMP_A_LOW);
  assign wr_cmp_b_low = wr && (adr_i == OFS_CMP_B_LOW);
  assign wr_irq_mask = wr && (adr_i == OFS_IRQ_MASK);
  assign wr_flags = wr && (adr_i == OFS_FLAGS);
  assign wr_cmp_ctrl = wr && (adr_i == OFS_CMP_CTRL);
  assign rd_cap_low = rd && (adr_i == OFS_CAP_LOW);

  // Every high byte location writes into the one shared holding register.
  assign wr_any_high = wr && (adr_i == OFS_CAP_HIGH || adr_i == OFS_CMP_A_HIGH || adr_i == OFS_CMP_B_HIGH);

  // Bus acknowledge: one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= access;
  end

  // Control registers; the mode bits are split over two registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_ctrl_a_ff <= CTRL_RESET;
      timer_ctrl_b_ff <= CTRL_RESET;
    end
    else
    begin
      if (wr_ctrl_a)
        timer_ctrl_a_ff <= dat_i[7:0];
      if (wr_ctrl_b)
        timer_ctrl_b_ff <= dat_i[7:0];
    end
  end

  // Interrupt enables and the comparator source select.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_mask_reg_ff <= 3'h0;
      comparator_capture_select_ff <= 1'b0;
    end
    else
    begin
      if (wr_irq_mask)
        irq_mask_reg_ff <= dat_i[2:0];
      if (wr_cmp_ctrl)
        comparator_capture_select_ff <= dat_i[CMP_CTRL_SELECT_BIT];
    end
  end

  assign mode = {timer_ctrl_b_ff[CTRL_B_WGM_LSB +: 2], timer_ctrl_a_ff[CTRL_A_WGM_LSB +: 2]};
  assign capture_enable = ~capture_is_ceiling(mode);

  // Holding register: filled by high byte writes and by capture low reads.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      holding_ff <= 8'h00;
    else if (wr_any_high)
      holding_ff <= dat_i[7:0];
    else if (rd_cap_low)
      holding_ff <= capture_register_ff[15:8];
  end

  // Input conditioning shares one synchroniser style for pin and comparator.
  capture_filter u_capture_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(capture_input_pin_i),
    .comparator_i(comparator_result_i),
    .source_select_i(comparator_capture_select_ff),
    .filter_enable_i(timer_ctrl_b_ff[CTRL_B_FILTER_BIT]),
    .rising_edge_i(timer_ctrl_b_ff[CTRL_B_EDGE_BIT]),
    .enable_i(capture_enable),
    .event_o(capture_event)
  );

  // Capture register: timestamps in measuring modes, ceiling value otherwise.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_register_ff <= VALUE_RESET;
    else if (capture_event)
      capture_register_ff <= counter_i.value;
    else if (wr_cap_low && capture_is_ceiling(mode))
      capture_register_ff <= {holding_ff, dat_i[7:0]};
  end

  // Capture flag: an event in the clearing cycle is kept.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      capture_flag_ff <= 1'b0;
    else if (capture_event)
      capture_flag_ff <= 1'b1;
    else if ((wr_flags && dat_i[FLAG_CAP_BIT]) || irq_ack_i[0])
      capture_flag_ff <= 1'b0;
  end

  // Compare settings; the action bits pass straight through, unbuffered.
  assign cfg_a.buffered = is_pwm(mode);
  assign cfg_a.floor_load = loads_at_floor(mode);
  assign cfg_a.action = timer_ctrl_a_ff[CTRL_A_ACT_A_LSB +: 2];
  assign cfg_b.buffered = is_pwm(mode);
  assign cfg_b.floor_load = loads_at_floor(mode);
  assign cfg_b.action = timer_ctrl_a_ff[CTRL_A_ACT_B_LSB +: 2];

  // Force strobes act only in the modes without buffering.
  assign force_a = wr_ctrl_c & dat_i[CTRL_C_FORCE_A_BIT] & ~is_pwm(mode);
  assign force_b = wr_ctrl_c & dat_i[CTRL_C_FORCE_B_BIT] & ~is_pwm(mode);
  assign clear_a = (wr_flags & dat_i[FLAG_CMP_A_BIT]) | irq_ack_i[1];
  assign clear_b = (wr_flags & dat_i[FLAG_CMP_B_BIT]) | irq_ack_i[2];

  compare_unit u_compare_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .counter_i(counter_i),
    .cfg_i(cfg_a),
    .commit_i(wr_cmp_a_low),
    .value_i({holding_ff, dat_i[7:0]}),
    .force_i(force_a),
    .flag_clear_i(clear_a),
    .cpu_view_o(view_a),
    .active_o(active_a),
    .match_o(match_a_o),
    .flag_o(flag_a),
    .state_o(state_a)
  );

  compare_unit u_compare_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .counter_i(counter_i),
    .cfg_i(cfg_b),
    .commit_i(wr_cmp_b_low),
    .value_i({holding_ff, dat_i[7:0]}),
    .force_i(force_b),
    .flag_clear_i(clear_b),
    .cpu_view_o(view_b),
    .active_o(active_b),
    .match_o(match_b_o),
    .flag_o(flag_b),
    .state_o(state_b)
  );

  // Ceiling for the counter: capture register in its modes, else compare A.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ceiling_ff <= VALUE_RESET;
    else if (capture_is_ceiling(mode))
      ceiling_ff <= capture_register_ff;
    else
      ceiling_ff <= active_a;
  end

  // Read multiplexer; compare reads go straight to the unit, not the holding register.
  always_comb
  begin
    nxt_rd_data = 8'h00;
    case (adr_i)
      OFS_CTRL_A: nxt_rd_data = timer_ctrl_a_ff;
      OFS_CTRL_B: nxt_rd_data = timer_ctrl_b_ff;
      OFS_CAP_LOW: nxt_rd_data = capture_register_ff[7:0];
      OFS_CAP_HIGH: nxt_rd_data = holding_ff;
      OFS_CMP_A_LOW: nxt_rd_data = view_a[7:0];
      OFS_CMP_A_HIGH: nxt_rd_data = view_a[15:8];
      OFS_CMP_B_LOW: nxt_rd_data = view_b[7:0];
      OFS_CMP_B_HIGH: nxt_rd_data = view_b[15:8];
      OFS_IRQ_MASK: nxt_rd_data = {5'h00, irq_mask_reg_ff};
      OFS_FLAGS: nxt_rd_data = {5'h00, flag_b, flag_a, capture_flag_ff};
      OFS_CMP_CTRL: nxt_rd_data = {7'h00, comparator_capture_select_ff};
      OFS_OUT_STATE: nxt_rd_data = {6'h00, state_b, state_a};
      default: nxt_rd_data = 8'h00;
    endcase
  end

  // Read data is registered when the request is taken and held until the next one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rd_data_ff <= 8'h00;
    else if (rd)
      rd_data_ff <= nxt_rd_data;
  end

  // Bus and side outputs.
  assign dat_o = {24'h000000, rd_data_ff};
  assign ack_o = ack_ff;
  assign capture_irq_o = capture_flag_ff & irq_mask_reg_ff[FLAG_CAP_BIT];
  assign compare_a_irq_o = flag_a & irq_mask_reg_ff[FLAG_CMP_A_BIT];
  assign compare_b_irq_o = flag_b & irq_mask_reg_ff[FLAG_CMP_B_BIT];
  assign waveform_mode_select_o = mode;
  assign ceiling_value_o = ceiling_ff;
  assign compare_output_state_o = {state_b, state_a};

endmodule : timer_capture_compare_units
`default_nettype wire

/* File: testbench/capcmp_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Ties bus answers, flags and output states to their causes at the ports.
module capcmp_checker
  import capcmp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus.
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic stb_i,
  input wire logic cyc_i,
  input wire logic ack_o,
  // Timer side and results.
  input wire counter_status_t counter_i,
  input wire logic capture_irq_o,
  input wire logic compare_a_irq_o,
  input wire logic [2:0] irq_ack_i,
  input wire logic match_a_o,
  input wire logic match_b_o,
  input wire logic [1:0] compare_output_state_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // The bus answers after exactly one cycle and never stretches the answer.
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held too long");
  rd_zero_a: assert property (ack_o && !we_i && adr_i > 8'h30 |-> dat_o == 32'h0) else $error("unmapped data");
  // Matches only come with a tick, and never on a tick in the cycle right after a counter write without a tick.
  match_tick_a: assert property (match_a_o || match_b_o |-> counter_i.tick)
    else $error("match without tick");
  match_block_a: assert property (counter_i.written && !counter_i.tick ##1 counter_i.tick
    |-> !match_a_o && !match_b_o) else $error("match not blocked");
  // Output states move only on a match or a bus write such as a force.
  state_hold_a: assert property ($changed(compare_output_state_o)
    |-> $past(match_a_o) || $past(match_b_o) || ($past(cyc_i) && $past(stb_i) && $past(we_i)))
    else $error("state moved");
  cap_clear_a: assert property ($fell(capture_irq_o)
    |-> $past(irq_ack_i[0]) || ($past(cyc_i) && $past(stb_i) && $past(we_i))) else $error("capture irq dropped");
  cmp_flag_a: assert property ($rose(compare_a_irq_o)
    |-> $past(match_a_o) || ($past(cyc_i) && $past(stb_i) && $past(we_i))) else $error("compare irq without match");
endmodule : capcmp_checker

bind timer_capture_compare_units capcmp_checker u_chk (.clk_i, .rst_i, .adr_i, .dat_o, .we_i, .stb_i,
  .cyc_i, .ack_o, .counter_i, .capture_irq_o, .compare_a_irq_o, .irq_ack_i, .match_a_o, .match_b_o,
  .compare_output_state_o);
`default_nettype wire

/* File: testbench/counter_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the 16-bit counter unit, stepped by the bench.
module counter_model
  import capcmp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Controls from the bench.
  input wire logic run_i,
  input wire logic load_i,
  input wire logic [15:0] load_value_i,
  // Status towards the block.
  output counter_status_t status_o
);
  logic [15:0] value_ff;

  // A CPU write wins over counting, as on the real counter.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      value_ff <= 16'h0000;
    else if (load_i)
      value_ff <= load_value_i;
    else if (run_i)
      value_ff <= value_ff + 16'h0001;
  end

  // The ceiling is the full range here; the block reports its own ceiling value.
  assign status_o = '{value: value_ff, tick: run_i, written: load_i,
                      at_top: value_ff == 16'hffff, at_floor: value_ff == 16'h0000};
endmodule : counter_model
`default_nettype wire

/* File: testbench/timer_capture_compare_units_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_capture_compare_units_bench;
  import capcmp_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, stb_i = 1'b0, cyc_i = 1'b0, ack_o;
  logic pin = 1'b0, cmpr = 1'b0, run = 1'b0, load = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic [3:0] sel_i = 4'h1;
  logic [2:0] irq_ack = 3'h0;
  logic [15:0] load_value = 16'h0000, ceil;
  logic [3:0] mode;
  logic [1:0] state;
  logic cap_irq, a_irq, b_irq, m_a, m_b;
  counter_status_t cnt;
  int n_mismatch = 0, checks_done = 0;

  // The clock runs at 10 MHz.
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  counter_model u_cnt (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .load_i(load), .load_value_i(load_value),
    .status_o(cnt));

  timer_capture_compare_units u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o), .capture_input_pin_i(pin),
    .comparator_result_i(cmpr), .counter_i(cnt), .capture_irq_o(cap_irq), .compare_a_irq_o(a_irq),
    .compare_b_irq_o(b_irq), .irq_ack_i(irq_ack), .match_a_o(m_a), .match_b_o(m_b),
    .waveform_mode_select_o(mode), .ceiling_value_o(ceil), .compare_output_state_o(state));

  task results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cy

  // One classic cycle: hold everything until ack is seen, then one idle cycle.
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (ack_o !== 1'b1)
    begin
      n_mismatch++;
      results();
    end
    @(posedge clk_i);
  endtask : wb

  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q[15:0], {8'h00, e});
  endtask : rd

  // Counter stimulus: a write pulse, then a run of ticks.
  task ld(input logic [15:0] v);
    load <= 1'b1;
    load_value <= v;
    @(posedge clk_i);
    load <= 1'b0;
  endtask : ld

  task tk(input int n);
    run <= 1'b1;
    cy(n);
    run <= 1'b0;
    @(posedge clk_i);
  endtask : tk

  task ack_irq(input logic [2:0] m);
    irq_ack <= m;
    @(posedge clk_i);
    irq_ack <= 3'h0;
    @(posedge clk_i);
  endtask : ack_irq

  task t_reset;
    rd(OFS_OUT_STATE, 8'h00);
    rd(OFS_FLAGS, 8'h00);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h00);
    sel_i <= 4'h0;
    wr(OFS_IRQ_MASK, 8'h07);
    sel_i <= 4'h1;
    rd(OFS_IRQ_MASK, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task t_capture;
    wr(OFS_IRQ_MASK, 8'h07);
    wr(OFS_CTRL_B, 8'h40);
    ld(16'h1234);
    pin <= 1'b1;
    cy(8);
    rd(OFS_FLAGS, 8'h01);
    rd(OFS_CAP_LOW, 8'h34);
    rd(OFS_CAP_HIGH, 8'h12);
    chk({15'h0, cap_irq}, 16'h0001);
    ack_irq(3'h1);
    chk({15'h0, cap_irq}, 16'h0000);
    wr(OFS_CTRL_B, 8'h00);
    ld(16'h5678);
    pin <= 1'b0;
    cy(8);
    rd(OFS_CAP_LOW, 8'h78);
    wr(OFS_FLAGS, 8'h01);
    rd(OFS_FLAGS, 8'h00);
    // Switching source may capture, so the flag is cleared afterwards.
    wr(OFS_CTRL_B, 8'h40);
    wr(OFS_CMP_CTRL, 8'h01);
    cy(8);
    wr(OFS_FLAGS, 8'h01);
    ld(16'h0abc);
    cmpr <= 1'b1;
    cy(8);
    rd(OFS_CAP_LOW, 8'hbc);
    wr(OFS_CMP_CTRL, 8'h00);
    cy(8);
    wr(OFS_FLAGS, 8'h01);
    // A two-cycle spike must not pass the filter; a steady level passes late.
    wr(OFS_CTRL_B, 8'hc0);
    pin <= 1'b1;
    cy(2);
    pin <= 1'b0;
    cy(14);
    rd(OFS_FLAGS, 8'h00);
    ld(16'h0077);
    pin <= 1'b1;
    cy(6);
    rd(OFS_FLAGS, 8'h00);
    cy(10);
    rd(OFS_CAP_LOW, 8'h77);
    $display("test capture done");
  endtask : t_capture

  task t_cap_write;
    wr(OFS_FLAGS, 8'h01);
    wr(OFS_CTRL_B, 8'h58);
    wr(OFS_CAP_HIGH, 8'hab);
    wr(OFS_CAP_LOW, 8'hcd);
    rd(OFS_CAP_LOW, 8'hcd);
    rd(OFS_CAP_HIGH, 8'hab);
    chk(ceil, 16'habcd);
    pin <= 1'b0;
    cy(8);
    pin <= 1'b1;
    cy(12);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_CTRL_B, 8'h40);
    wr(OFS_CAP_HIGH, 8'h11);
    wr(OFS_CAP_LOW, 8'h22);
    rd(OFS_CAP_LOW, 8'hcd);
    $display("test capture write done");
  endtask : t_cap_write

  task t_compare;
    wr(OFS_CTRL_A, 8'h70);
    wr(OFS_CMP_A_HIGH, 8'h00);
    wr(OFS_CMP_A_LOW, 8'h10);
    wr(OFS_CMP_B_HIGH, 8'h00);
    wr(OFS_CMP_B_LOW, 8'h11);
    rd(OFS_CMP_A_LOW, 8'h10);
    rd(OFS_CAP_LOW, 8'hcd);
    rd(OFS_CMP_B_HIGH, 8'h00);
    ld(16'h000c);
    tk(8);
    rd(OFS_FLAGS, 8'h06);
    rd(OFS_OUT_STATE, 8'h03);
    chk({14'h0, a_irq, b_irq}, 16'h0003);
    ack_irq(3'h6);
    chk({14'h0, a_irq, b_irq}, 16'h0000);
    // A counter write just before the tick hides a real match.
    ld(16'h0010);
    tk(1);
    rd(OFS_FLAGS, 8'h00);
    $display("test compare done");
  endtask : t_compare

  task t_force;
    wr(OFS_CTRL_A, 8'hb0);
    wr(OFS_CTRL_C, 8'h80);
    rd(OFS_OUT_STATE, 8'h02);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_CTRL_A, 8'ha3);
    wr(OFS_CTRL_B, 8'h18);
    chk({12'h0, mode}, 16'h000f);
    rd(OFS_OUT_STATE, 8'h02);
    wr(OFS_CTRL_C, 8'h40);
    rd(OFS_OUT_STATE, 8'h02);
    chk(ceil, 16'h0010);
    wr(OFS_CMP_A_HIGH, 8'h00);
    wr(OFS_CMP_A_LOW, 8'h20);
    cy(1);
    chk(ceil, 16'h0010);
    ld(16'hffff);
    tk(1);
    cy(1);
    chk(ceil, 16'h0020);
    // Mode 9 loads the buffer at the floor only, not at the top.
    wr(OFS_CTRL_B, 8'h10);
    wr(OFS_CTRL_A, 8'h01);
    wr(OFS_CMP_A_LOW, 8'h30);
    ld(16'hffff);
    tk(1);
    chk(ceil, 16'h0020);
    tk(1);
    cy(1);
    chk(ceil, 16'h0030);
    $display("test force and buffer done");
  endtask : t_force

  // Reset for five cycles, then run every scenario in turn.
  initial
  begin
    cy(5);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_capture();
    t_cap_write();
    t_compare();
    t_force();
    results();
  end
endmodule : timer_capture_compare_units_bench
`default_nettype wire
